// ### inc/pdsa_pkg.sv
// Shared constants and types for the dual-channel PCI to SCSI adapter core
package pdsa_pkg;
  // PCI command encodings
  localparam logic [3:0] PDSA_CMD_INTA = 4'h0;
  localparam logic [3:0] PDSA_CMD_SPECIAL = 4'h1;
  localparam logic [3:0] PDSA_CMD_IO_RD = 4'h2;
  localparam logic [3:0] PDSA_CMD_IO_WR = 4'h3;
  localparam logic [3:0] PDSA_CMD_MEM_RD = 4'h6;
  localparam logic [3:0] PDSA_CMD_MEM_WR = 4'h7;
  localparam logic [3:0] PDSA_CMD_CFG_RD = 4'ha;
  localparam logic [3:0] PDSA_CMD_CFG_WR = 4'hb;
  localparam logic [3:0] PDSA_CMD_MEM_RD_MULT = 4'hc;
  localparam logic [3:0] PDSA_CMD_DAC = 4'hd;
  localparam logic [3:0] PDSA_CMD_MEM_RD_LINE = 4'he;
  localparam logic [3:0] PDSA_CMD_MEM_WR_INV = 4'hf;
  // Per-channel register space
  localparam int PDSA_NUM_REGS = 4;
  localparam logic [1:0] PDSA_REG_CTRL = 2'h0;
  localparam logic [1:0] PDSA_REG_CACHE_LINE = 2'h1;
  localparam logic [1:0] PDSA_REG_SYNC = 2'h2;
  localparam logic [1:0] PDSA_REG_STATUS = 2'h3;
  // Control register field positions
  localparam int PDSA_CTRL_RDLINE_SEL = 0;
  localparam int PDSA_CTRL_WIDE = 1;
  localparam int PDSA_CTRL_FAST20 = 2;
  localparam int PDSA_CTRL_TERM_OFF = 3;
  localparam int PDSA_CTRL_DIFF = 4;
  localparam int PDSA_CTRL_IRQ_EN = 5;
  localparam logic [31:0] PDSA_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PDSA_CACHE_LINE_RESET = 32'h0000_0008;
  // Channel identity and segment size
  localparam int PDSA_WIDE_CHANNEL = 0;
  localparam int PDSA_NARROW_CHANNEL = 1;
  localparam int PDSA_MAX_TARGETS = 15;
  // Transfer clock divisors at 100 MHz: Fast-10 100 ns, Fast-20 50 ns per transfer
  localparam int PDSA_CLK_NS = 10;
  localparam int PDSA_FAST10_NS = 100;
  localparam int PDSA_FAST20_NS = 50;
  localparam logic [3:0] PDSA_FAST10_CYC = 4'(PDSA_FAST10_NS / PDSA_CLK_NS);
  localparam logic [3:0] PDSA_FAST20_CYC = 4'(PDSA_FAST20_NS / PDSA_CLK_NS);
  // Master burst states
  typedef enum logic [2:0] {
    PDSA_M_IDLE = 3'b001,
    PDSA_M_ADDR = 3'b010,
    PDSA_M_DATA = 3'b100
  } pdsa_mst_e;
endpackage : pdsa_pkg

// ### src/pdsa_scsi_channel.sv
// One SCSI channel: per-byte odd parity, wide/narrow lanes, transfer pacing, power-down gating
`timescale 1ns/1ps
module pdsa_scsi_channel
#(
  parameter bit WIDE_CAPABLE = 1'b1
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic power_down,
  input wire logic wide_mode,
  input wire logic fast20,
  input wire logic tx_valid,
  input wire logic [15:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [15:0] rx_data,
  output logic rx_parity_error,
  output logic [15:0] scsi_data_out,
  output logic [1:0] scsi_parity_out,
  output logic [1:0] scsi_data_oe,
  input wire logic [15:0] scsi_data_in,
  input wire logic [1:0] scsi_parity_in,
  input wire logic scsi_strobe_in,
  output logic scsi_strobe_out,
  output logic busy
);
  import pdsa_pkg::*;

  typedef struct packed {
    logic [3:0] pace;
    logic [15:0] dout;
    logic [1:0] pout;
    logic [1:0] oe;
    logic strobe;
    logic rxv;
    logic [15:0] rxd;
    logic perr;
  } pdsa_ch_s;

  pdsa_ch_s state_reg;
  pdsa_ch_s state_next;
  logic wide_eff;
  logic [15:0] in_gated;
  logic [1:0] par_in_gated;
  logic strobe_gated;

  assign wide_eff = WIDE_CAPABLE && wide_mode;
  // Power-down forces every SCSI bus input to a quiet level narrow mode masks high byte
  assign in_gated = power_down ? 16'h0000 : {wide_eff ? scsi_data_in[15:8] : 8'h00, scsi_data_in[7:0]};
  assign par_in_gated = power_down ? 2'h3 : {wide_eff ? scsi_parity_in[1] : 1'b1, scsi_parity_in[0]};
  assign strobe_gated = !power_down && scsi_strobe_in;
  assign tx_ready = !power_down && state_reg.pace == 4'h0;

  always_comb
  begin
    state_next = state_reg;
    state_next.rxv = 1'b0;
    state_next.strobe = 1'b0;
    if (state_reg.pace != 4'h0)
    begin
      state_next.pace = state_reg.pace - 4'h1;
    end
    // Same control and pacing for either width; rate set by Fast-10/Fast-20
    if (tx_valid && tx_ready)
    begin
      state_next.pace = fast20 ? PDSA_FAST20_CYC - 4'h1 : PDSA_FAST10_CYC - 4'h1;
      state_next.dout = {wide_eff ? tx_data[15:8] : 8'h00, tx_data[7:0]};
      state_next.pout = {~^tx_data[15:8], ~^tx_data[7:0]};
      state_next.oe = {wide_eff, 1'b1};
      state_next.strobe = 1'b1;
    end
    else if (state_reg.pace == 4'h0)
    begin
      state_next.oe = 2'h0;
    end
    if (strobe_gated)
    begin
      state_next.rxv = 1'b1;
      state_next.rxd = in_gated;
      // Odd parity check per active byte
      state_next.perr = (^{in_gated[7:0], par_in_gated[0]} == 1'b0) ||
        (wide_eff && ^{in_gated[15:8], par_in_gated[1]} == 1'b0);
    end
    if (reset)
    begin
      state_next = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    state_reg <= state_next;
  end

  assign rx_valid = state_reg.rxv;
  assign rx_data = state_reg.rxd;
  assign rx_parity_error = state_reg.perr;
  assign scsi_data_out = state_reg.dout;
  assign scsi_parity_out = state_reg.pout;
  assign scsi_data_oe = state_reg.oe;
  assign scsi_strobe_out = state_reg.strobe;
  assign busy = state_reg.oe != 2'h0;

  a_tx_parity_odd: assert property (@(posedge clk) disable iff (reset)
    state_reg.strobe |-> (^{state_reg.dout[7:0], state_reg.pout[0]} == 1'b1) &&
      (!state_reg.oe[1] || ^{state_reg.dout[15:8], state_reg.pout[1]} == 1'b1))
    else $error("byte parity not odd");
  a_pdown_no_rx: assert property (@(posedge clk) disable iff (reset)
    power_down |=> !state_reg.rxv)
    else $error("input accepted in power down");
  a_narrow_hi_off: assert property (@(posedge clk) disable iff (reset)
    !wide_eff && state_reg.strobe |-> state_reg.oe[1] == 1'b0)
    else $error("high byte driven in narrow mode");
endmodule : pdsa_scsi_channel

// ### src/pdsa_adapter.sv
// Dual-channel PCI to SCSI adapter core: target decode, master command choice, two channels
`timescale 1ns/1ps
module pdsa_adapter
(
  input wire logic clk,
  input wire logic reset,
  input wire logic power_down,
  input wire logic pci_addr_valid,
  input wire logic [3:0] pci_cmd,
  input wire logic [31:0] pci_addr,
  input wire logic [2:0] pci_cfg_function,
  input wire logic pci_wr_valid,
  input wire logic [31:0] pci_wdata,
  input wire logic [3:0] pci_byte_en,
  input wire logic pci_par_in,
  output logic pci_claim,
  output logic pci_rd_valid,
  output logic [31:0] pci_rdata,
  output logic pci_par_out,
  output logic pci_parity_err_n,
  output logic pci_system_err_n,
  output logic wide_channel_irq_line,
  output logic narrow_channel_irq_line,
  input wire logic [1:0] mst_req,
  input wire logic [1:0] mst_read,
  input wire logic [31:0] mst_addr0,
  input wire logic [31:0] mst_addr1,
  input wire logic mst_grant,
  output logic mst_start,
  output logic [3:0] mst_cmd,
  output logic [31:0] mst_addr,
  output logic [7:0] mst_burst_len,
  output logic mst_channel,
  output logic mst_data_phase,
  input wire logic mst_data_ack,
  output logic [15:0] scsi0_data_out,
  output logic [1:0] scsi0_parity_out,
  output logic [1:0] scsi0_data_oe,
  input wire logic [15:0] scsi0_data_in,
  input wire logic [1:0] scsi0_parity_in,
  input wire logic scsi0_strobe_in,
  output logic scsi0_strobe_out,
  output logic [15:0] scsi1_data_out,
  output logic [1:0] scsi1_parity_out,
  output logic [1:0] scsi1_data_oe,
  input wire logic [15:0] scsi1_data_in,
  input wire logic [1:0] scsi1_parity_in,
  input wire logic scsi1_strobe_in,
  output logic scsi1_strobe_out,
  output logic [1:0] scsi_diff_ctrl,
  output logic [1:0] scsi_activity_led,
  output logic [1:0] scsi_term_power_down_n,
  output logic [3:0] scsi0_arb_winner,
  input wire logic [15:0] scsi0_arb_ids
);
  import pdsa_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0][PDSA_NUM_REGS-1:0][31:0] regs;
    logic claim;
    logic rdv;
    logic [31:0] rdata;
    logic par_out;
    logic perr;
    logic serr;
    pdsa_mst_e mst;
    logic [3:0] cmd;
    logic [31:0] maddr;
    logic [7:0] blen;
    logic mch;
    logic [1:0] irq;
    logic [3:0] arb;
  } pdsa_top_s;

  pdsa_top_s state_reg;
  pdsa_top_s state_next;

  logic hit_mem;
  logic hit_io;
  logic hit_cfg;
  logic is_write;
  logic supported;
  logic [1:0] sel_ch;
  logic [1:0] reg_idx;
  logic [1:0] tx_ready;
  logic [1:0] rx_valid;
  logic [1:0][15:0] rx_data;
  logic [1:0] rx_perr;
  logic [1:0] ch_busy;
  logic [1:0][15:0] ch_in;
  logic [1:0][1:0] ch_pin;
  logic [1:0] ch_sin;
  logic [1:0][15:0] ch_dout;
  logic [1:0][1:0] ch_pout;
  logic [1:0][1:0] ch_oe;
  logic [1:0] ch_sout;
  logic [1:0] tx_valid;

  // ==========================================================
  // Target command decode
  always_comb
  begin
    hit_mem = 1'b0;
    hit_io = 1'b0;
    hit_cfg = 1'b0;
    is_write = 1'b0;
    case (pci_cmd)
      PDSA_CMD_IO_RD: hit_io = 1'b1;
      PDSA_CMD_IO_WR:
      begin
        hit_io = 1'b1;
        is_write = 1'b1;
      end
      PDSA_CMD_MEM_RD, PDSA_CMD_MEM_RD_MULT, PDSA_CMD_MEM_RD_LINE: hit_mem = 1'b1;
      PDSA_CMD_MEM_WR, PDSA_CMD_MEM_WR_INV:
      begin
        hit_mem = 1'b1;
        is_write = 1'b1;
      end
      PDSA_CMD_CFG_RD: hit_cfg = 1'b1;
      PDSA_CMD_CFG_WR:
      begin
        hit_cfg = 1'b1;
        is_write = 1'b1;
      end
      default: hit_mem = 1'b0;
    endcase
  end

  assign supported = hit_mem || hit_io || hit_cfg;
  // Function 0 is the wide channel, function 1 the narrow one
  assign sel_ch[0] = hit_cfg ? pci_cfg_function == 3'h0 : !pci_addr[8];
  assign sel_ch[1] = hit_cfg ? pci_cfg_function == 3'h1 : pci_addr[8];
  assign reg_idx = pci_addr[3:2];

  // ==========================================================
  // Channels
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_ch
      // Channel 0 wide, channel 1 narrow
      pdsa_scsi_channel #(.WIDE_CAPABLE(g == PDSA_WIDE_CHANNEL)) u_ch
      (
        .clk(clk),
        .reset(reset),
        .power_down(power_down),
        .wide_mode(state_reg.regs[g][PDSA_REG_CTRL][PDSA_CTRL_WIDE]),
        .fast20(state_reg.regs[g][PDSA_REG_CTRL][PDSA_CTRL_FAST20]),
        .tx_valid(tx_valid[g]),
        .tx_data(pci_wdata[15:0]),
        .tx_ready(tx_ready[g]),
        .rx_valid(rx_valid[g]),
        .rx_data(rx_data[g]),
        .rx_parity_error(rx_perr[g]),
        .scsi_data_out(ch_dout[g]),
        .scsi_parity_out(ch_pout[g]),
        .scsi_data_oe(ch_oe[g]),
        .scsi_data_in(ch_in[g]),
        .scsi_parity_in(ch_pin[g]),
        .scsi_strobe_in(ch_sin[g]),
        .scsi_strobe_out(ch_sout[g]),
        .busy(ch_busy[g])
      );
      // Data write to the FIFO window (offset 0x80) launches a transfer only with good PCI parity
      assign tx_valid[g] = pci_addr_valid && pci_wr_valid && hit_io && sel_ch[g] && pci_addr[7] &&
        !(^{pci_wdata, pci_cmd, pci_par_in});
      assign scsi_diff_ctrl[g] = state_reg.regs[g][PDSA_REG_CTRL][PDSA_CTRL_DIFF];
      assign scsi_activity_led[g] = ch_busy[g] || rx_valid[g];
      assign scsi_term_power_down_n[g] = 1'b1;
    end
  endgenerate

  assign ch_in[0] = scsi0_data_in;
  assign ch_in[1] = scsi1_data_in;
  assign ch_pin[0] = scsi0_parity_in;
  assign ch_pin[1] = scsi1_parity_in;
  assign ch_sin[0] = scsi0_strobe_in;
  assign ch_sin[1] = scsi1_strobe_in;
  assign scsi0_data_out = ch_dout[0];
  assign scsi1_data_out = ch_dout[1];
  assign scsi0_parity_out = ch_pout[0];
  assign scsi1_parity_out = ch_pout[1];
  assign scsi0_data_oe = ch_oe[0];
  assign scsi1_data_oe = ch_oe[1];
  assign scsi0_strobe_out = ch_sout[0];
  assign scsi1_strobe_out = ch_sout[1];

  // ==========================================================
  // Next state
  always_comb
  begin
    state_next = state_reg;
    state_next.claim = 1'b0;
    state_next.rdv = 1'b0;
    state_next.perr = 1'b0;
    state_next.serr = 1'b0;
    // Low byte IDs win: scan from bit 15 down to bit 0, lowest set bit kept, cap at 15 others plus self
    state_next.arb = 4'hf;
    for (int i = PDSA_MAX_TARGETS; i >= 0; i--)
    begin
      if (scsi0_arb_ids[i])
      begin
        state_next.arb = 4'(i);
      end
    end
    if (pci_addr_valid && supported && sel_ch != 2'h0)
    begin
      state_next.claim = 1'b1;
      if (is_write && pci_wr_valid)
      begin
        // Check incoming PCI parity; bad data is not stored
        if ((^{pci_wdata, pci_cmd, pci_par_in}) != 1'b0)
        begin
          state_next.perr = 1'b1;
          state_next.serr = hit_cfg;
        end
        else if (!(hit_io && pci_addr[7]))
        begin
          for (int c = 0; c < 2; c++)
          begin
            if (sel_ch[c] && reg_idx != PDSA_REG_STATUS)
            begin
              for (int b = 0; b < 4; b++)
              begin
                if (pci_byte_en[b])
                begin
                  state_next.regs[c][reg_idx][b*8 +: 8] = pci_wdata[b*8 +: 8];
                end
              end
            end
          end
        end
      end
      else if (!is_write)
      begin
        state_next.rdv = 1'b1;
        state_next.rdata = sel_ch[1] ? state_reg.regs[1][reg_idx] : state_reg.regs[0][reg_idx];
        state_next.par_out = ^(sel_ch[1] ? state_reg.regs[1][reg_idx] : state_reg.regs[0][reg_idx]) ^ ^pci_cmd;
      end
    end
    for (int c = 0; c < 2; c++)
    begin
      state_next.regs[c][PDSA_REG_STATUS] = {13'h0000, ch_busy[c], rx_perr[c], tx_ready[c], rx_data[c]};
      // SCSI-side parity error sets the channel interrupt; set wins over clear
      if (rx_valid[c] && rx_perr[c] && state_reg.regs[c][PDSA_REG_CTRL][PDSA_CTRL_IRQ_EN])
      begin
        state_next.irq[c] = 1'b1;
      end
      else if (!state_reg.regs[c][PDSA_REG_CTRL][PDSA_CTRL_IRQ_EN])
      begin
        state_next.irq[c] = 1'b0;
      end
    end
    // Shared bus master, channel 0 first
    case (state_reg.mst)
      PDSA_M_IDLE:
      begin
        if (mst_req != 2'h0)
        begin
          state_next.mch = !mst_req[0];
          state_next.maddr = mst_req[0] ? mst_addr0 : mst_addr1;
          // Read line or read multiple by control register bit; never config
          if (mst_read[mst_req[0] ? 0 : 1])
          begin
            state_next.cmd = state_reg.regs[mst_req[0] ? 0 : 1][PDSA_REG_CTRL][PDSA_CTRL_RDLINE_SEL] ?
              PDSA_CMD_MEM_RD_LINE : PDSA_CMD_MEM_RD_MULT;
          end
          else
          begin
            state_next.cmd = PDSA_CMD_MEM_WR_INV;
          end
          state_next.blen = state_reg.regs[mst_req[0] ? 0 : 1][PDSA_REG_CACHE_LINE][7:0];
          state_next.mst = PDSA_M_ADDR;
        end
      end
      PDSA_M_ADDR:
      begin
        if (mst_grant)
        begin
          state_next.mst = PDSA_M_DATA;
        end
      end
      PDSA_M_DATA:
      begin
        if (mst_data_ack)
        begin
          state_next.blen = state_reg.blen - 8'h01;
          if (state_reg.blen <= 8'h01)
          begin
            state_next.mst = PDSA_M_IDLE;
          end
        end
      end
      default: state_next.mst = PDSA_M_IDLE;
    endcase
    if (reset)
    begin
      state_next = '0;
      state_next.mst = PDSA_M_IDLE;
      state_next.arb = 4'hf;
      for (int c = 0; c < 2; c++)
      begin
        state_next.regs[c][PDSA_REG_CTRL] = PDSA_CTRL_RESET;
        state_next.regs[c][PDSA_REG_CACHE_LINE] = PDSA_CACHE_LINE_RESET;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    state_reg <= state_next;
  end

  // ==========================================================
  // Outputs
  assign pci_claim = state_reg.claim;
  assign pci_rd_valid = state_reg.rdv;
  assign pci_rdata = state_reg.rdata;
  assign pci_par_out = state_reg.par_out;
  assign pci_parity_err_n = !state_reg.perr;
  assign pci_system_err_n = !state_reg.serr;
  assign wide_channel_irq_line = !state_reg.irq[PDSA_WIDE_CHANNEL];
  assign narrow_channel_irq_line = !state_reg.irq[PDSA_NARROW_CHANNEL];
  assign mst_start = state_reg.mst == PDSA_M_ADDR;
  assign mst_cmd = state_reg.cmd;
  assign mst_addr = state_reg.maddr;
  assign mst_burst_len = state_reg.blen;
  assign mst_channel = state_reg.mch;
  assign mst_data_phase = state_reg.mst == PDSA_M_DATA;
  assign scsi0_arb_winner = state_reg.arb;

  // ==========================================================
  // Assertions
  sequence s_unsupported;
    pci_addr_valid && !supported;
  endsequence
  a_unsup_no_claim: assert property (@(posedge clk) disable iff (reset)
    s_unsupported |=> !pci_claim)
    else $error("unsupported command claimed");
  a_mst_no_cfg: assert property (@(posedge clk) disable iff (reset)
    mst_start |-> mst_cmd != PDSA_CMD_CFG_RD && mst_cmd != PDSA_CMD_CFG_WR)
    else $error("master issued config cycle");
  a_rdline_sel: assert property (@(posedge clk) disable iff (reset)
    $rose(mst_start) && (mst_cmd == PDSA_CMD_MEM_RD_LINE || mst_cmd == PDSA_CMD_MEM_RD_MULT) |-> mst_cmd ==
      (state_reg.regs[mst_channel][PDSA_REG_CTRL][PDSA_CTRL_RDLINE_SEL] ? PDSA_CMD_MEM_RD_LINE : PDSA_CMD_MEM_RD_MULT))
    else $error("read command select wrong");
  a_burst_len: assert property (@(posedge clk) disable iff (reset)
    $rose(mst_start) |-> mst_burst_len == state_reg.regs[mst_channel][PDSA_REG_CACHE_LINE][7:0])
    else $error("burst not sized from cache line");
  a_term_on: assert property (@(posedge clk) disable iff (reset)
    scsi_term_power_down_n == 2'h3)
    else $error("termination power dropped");
  a_rdline_claim: assert property (@(posedge clk) disable iff (reset)
    pci_addr_valid && pci_cmd == PDSA_CMD_MEM_RD_LINE && sel_ch != 2'h0 |=> pci_claim && pci_rd_valid)
    else $error("read line not handled as read");
  a_perr_flag: assert property (@(posedge clk) disable iff (reset)
    pci_addr_valid && supported && sel_ch != 2'h0 && is_write && pci_wr_valid &&
      (^{pci_wdata, pci_cmd, pci_par_in}) |=> !pci_parity_err_n)
    else $error("parity error not reported");
  a_irq_wide: assert property (@(posedge clk) disable iff (reset)
    rx_valid[0] && rx_perr[0] && state_reg.regs[0][PDSA_REG_CTRL][PDSA_CTRL_IRQ_EN] |=> !wide_channel_irq_line)
    else $error("wide irq not raised");
endmodule : pdsa_adapter

// ### tb/pdsa_far_model.sv
// Far-side model: host bridge burst responder and channel 0 SCSI receiver
`timescale 1ns/1ps
module pdsa_far_model
(
  input wire logic clk,
  input wire logic start,
  input wire logic dphase,
  output logic grant = 1'b0,
  output logic ack = 1'b0,
  input wire logic [15:0] sd,
  input wire logic [1:0] sp,
  input wire logic [1:0] soe,
  input wire logic sstb,
  output logic [15:0] got = 16'h0,
  output int acks = 0,
  output int badp = 0
);
  // ==========
  // Responder
  // Everything but the ack counter moves or samples on the falling edge, where the design's outputs are settled
  always @(negedge clk)
  begin
    grant <= start;
    ack <= dphase;
    if (sstb)
      got <= sd;
    // Odd parity on each driven byte
    if (sstb && ((soe[0] && !(^{sd[7:0], sp[0]})) || (soe[1] && !(^{sd[15:8], sp[1]}))))
      badp <= badp + 1;
  end
  // Ack is only raised while the design sits in its data phase, so each high ack at a rising edge is one word
  always @(posedge clk)
  begin
    if (ack)
      acks <= acks + 1;
  end
endmodule : pdsa_far_model

// ### tb/pci_dual_scsi_host_adapter_tb.sv
// Self-checking bench for the dual-channel PCI to SCSI adapter core
`timescale 1ns/1ps
module pci_dual_scsi_host_adapter_tb;
  import pdsa_pkg::*;
  localparam logic [15:0] SUPP = 16'hdccc;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic pdn = 1'b0;
  logic av = 1'b0;
  logic wv = 1'b0;
  logic pin = 1'b0;
  logic strb = 1'b0;
  logic [3:0] cmd = 4'h0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wd = 32'h0;
  logic [1:0] req = 2'h0;
  logic [1:0] rdir = 2'h0;
  logic [1:0] par0 = 2'h0;
  logic [15:0] din0 = 16'h0;
  logic [15:0] ids = 16'h0;
  logic [2:0] fn = 3'h0;
  logic [31:0] ma0 = 32'h0;
  logic ok, pe, se, claim, rdv, pout, perr_n, serr_n, irq_w, irq_n, ms, gr, ack, mch, mdp, s0s;
  logic [31:0] rd, rdata, maddr;
  logic [3:0] mcmd, arbw;
  logic [7:0] mlen;
  logic [15:0] s0d, got, s1d;
  logic [1:0] s0p, s0oe, tpd_n, s1oe, led, dif;
  int acks, badp;
  int fail_count = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  pdsa_adapter pdsa_adapter_i (.clk(clk), .reset(reset), .power_down(pdn), .pci_addr_valid(av), .pci_cmd(cmd),
    .pci_addr(addr), .pci_cfg_function(fn), .pci_wr_valid(wv), .pci_wdata(wd), .pci_byte_en(4'hf),
    .pci_par_in(pin), .pci_claim(claim), .pci_rd_valid(rdv), .pci_rdata(rdata), .pci_par_out(pout),
    .pci_parity_err_n(perr_n), .pci_system_err_n(serr_n), .wide_channel_irq_line(irq_w),
    .narrow_channel_irq_line(irq_n), .mst_req(req), .mst_read(rdir), .mst_addr0(ma0), .mst_addr1(wd),
    .mst_grant(gr), .mst_start(ms), .mst_cmd(mcmd), .mst_addr(maddr), .mst_burst_len(mlen), .mst_channel(mch),
    .mst_data_phase(mdp), .mst_data_ack(ack), .scsi0_data_out(s0d), .scsi0_parity_out(s0p),
    .scsi0_data_oe(s0oe), .scsi0_data_in(din0), .scsi0_parity_in(par0), .scsi0_strobe_in(strb),
    .scsi0_strobe_out(s0s), .scsi1_data_out(s1d), .scsi1_parity_out(), .scsi1_data_oe(s1oe),
    .scsi1_data_in(16'h0), .scsi1_parity_in(2'h0), .scsi1_strobe_in(1'b0), .scsi1_strobe_out(),
    .scsi_diff_ctrl(dif), .scsi_activity_led(led), .scsi_term_power_down_n(tpd_n), .scsi0_arb_winner(arbw),
    .scsi0_arb_ids(ids));
  pdsa_far_model pdsa_far_model_i (.clk(clk), .start(ms), .dphase(mdp), .grant(gr), .ack(ack), .sd(s0d),
    .sp(s0p), .soe(s0oe), .sstb(s0s), .got(got), .acks(acks), .badp(badp));
  // ==========
  // Shared tasks
  task automatic check(input logic good, input string what);
    total_checks++;
    if (good !== 1'b1)
    begin
      fail_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : check
  task automatic pci(input logic [3:0] c, input logic [31:0] a, input logic w, input logic [31:0] d, input logic b);
    cmd = c;
    addr = a;
    wd = d;
    wv = w;
    pin = (^{d, c}) ^ b;
    av = 1'b1;
    @(negedge clk);
    av = 1'b0;
    wv = 1'b0;
    ok = claim;
    pe = perr_n;
    se = serr_n;
    rd = rdata;
    if (rdv === 1'b1)
      check(pout === (^{rdata, c}), "read parity");
    @(negedge clk);
  endtask : pci
  task automatic rx(input logic [1:0] p);
    din0 = 16'h00ff;
    par0 = p;
    strb = 1'b1;
    @(negedge clk);
    strb = 1'b0;
    din0 = 16'hff00;
    par0 = ~p;
    repeat (4) @(negedge clk);
  endtask : rx
  // ==========
  // Scenarios
  task automatic t_cmds;
    for (int i = 0; i < 16; i++)
    begin
      pci(4'(i), 32'h4, i[0], 32'h8, 1'b0);
      check(ok === SUPP[i], "claim");
      if (SUPP[i] && !i[0])
        check(rd === 32'h8, "read data");
    end
  endtask : t_cmds
  task automatic t_par;
    pci(PDSA_CMD_MEM_WR_INV, 32'h4, 1'b1, 32'h3, 1'b1);
    check(pe === 1'b0, "no parity error");
    pci(PDSA_CMD_CFG_WR, 32'h4, 1'b1, 32'h3, 1'b1);
    check(se === 1'b0, "no system error");
    pci(PDSA_CMD_MEM_RD, 32'h4, 1'b0, 32'h0, 1'b0);
    check(rd === 32'h8, "bad write stored");
    pci(PDSA_CMD_MEM_WR_INV, 32'h4, 1'b1, 32'h3, 1'b0);
    pci(PDSA_CMD_MEM_RD, 32'h104, 1'b0, 32'h0, 1'b0);
    check(rd === 32'h8, "narrow changed");
    pci(PDSA_CMD_MEM_RD_LINE, 32'h4, 1'b0, 32'h0, 1'b0);
    check(rd === 32'h3, "write lost");
  endtask : t_par
  task automatic t_mst(input logic r, input logic [31:0] ctl, input logic [3:0] ec);
    int a0;
    pci(PDSA_CMD_MEM_WR, 32'h0, 1'b1, ctl, 1'b0);
    a0 = acks;
    rdir = {1'b0, r};
    ma0 = 32'h0000_1040;
    req = 2'b01;
    for (int n = 0; n < 20 && ms !== 1'b1; n++)
      @(negedge clk);
    req = 2'b00;
    check(mcmd === ec && mlen === 8'h3 && mch === 1'b0, "master command");
    check(maddr === 32'h0000_1040, "master address");
    for (int n = 0; n < 40 && acks - a0 < 3; n++)
      @(negedge clk);
    @(negedge clk);
    check(acks - a0 == 3 && mdp === 1'b0, "burst length");
  endtask : t_mst
  task automatic t_scsi;
    pci(PDSA_CMD_IO_WR, 32'h0, 1'b1, 32'h2e, 1'b0);
    pci(PDSA_CMD_IO_WR, 32'h80, 1'b1, 32'h1234, 1'b0);
    @(negedge clk);
    check(got === 16'h1234 && badp == 0 && tpd_n === 2'b11, "sent word");
    rx(2'b11);
    check(irq_w === 1'b1, "good parity flagged");
    pdn = 1'b1;
    rx(2'b00);
    check(irq_w === 1'b1, "input in power-down");
    pdn = 1'b0;
    rx(2'b00);
    check(irq_w === 1'b0 && irq_n === 1'b1, "irq line");
    ids = 16'h0a00;
    repeat (2) @(negedge clk);
    check(arbw === 4'h9, "arbitration");
    ids = 16'h8a10;
    @(negedge clk);
    check(arbw === 4'h4, "low byte priority");
  endtask : t_scsi
  task automatic t_narrow;
    pci(PDSA_CMD_IO_WR, 32'h100, 1'b1, 32'h12, 1'b0);
    pci(PDSA_CMD_IO_WR, 32'h180, 1'b1, 32'habcd, 1'b0);
    check(s1oe === 2'b01 && s1d === 16'h00cd, "narrow lanes");
    check(dif === 2'b10 && led === 2'b10, "transceiver and activity");
    repeat (PDSA_FAST10_CYC - 2) @(negedge clk);
    check(s1oe === 2'b01, "pace too short");
    @(negedge clk);
    check(s1oe === 2'b00, "pace too long");
    pci(PDSA_CMD_IO_WR, 32'h180, 1'b1, 32'h55, 1'b1);
    check(s1d === 16'h00cd && pe === 1'b0, "bad parity sent");
    fn = 3'h1;
    pci(PDSA_CMD_CFG_RD, 32'h4, 1'b0, 32'h0, 1'b0);
    check(ok === 1'b1 && rd === 32'h8, "function 1 read");
    fn = 3'h2;
    pci(PDSA_CMD_CFG_RD, 32'h4, 1'b0, 32'h0, 1'b0);
    check(ok === 1'b0, "function 2 claimed");
    fn = 3'h0;
  endtask : t_narrow
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    check(arbw === 4'hf && irq_w === 1'b1, "reset state");
    t_cmds();
    t_par();
    t_mst(1'b1, 32'h1, PDSA_CMD_MEM_RD_LINE);
    t_mst(1'b1, 32'h0, PDSA_CMD_MEM_RD_MULT);
    t_mst(1'b0, 32'h0, PDSA_CMD_MEM_WR_INV);
    t_scsi();
    t_narrow();
    report_and_stop();
  end
  initial
  begin
    #50000;
    fail_count++;
    report_and_stop();
  end
endmodule : pci_dual_scsi_host_adapter_tb
